// ---- rtl/tcf_regs.vh ----
// register map, field positions and mode codes of the timer capture and flag block
// assumes a 32-bit AHB-Lite bus; each 8-bit register sits in the low byte of one word
`ifndef TCF_REGS_VH
`define TCF_REGS_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define TCF_A_CAP1_LO 8'h00
`define TCF_A_CAP1_HI 8'h04
`define TCF_A_CAP3_LO 8'h08
`define TCF_A_CAP3_HI 8'h0c
`define TCF_A_IRQ_EN 8'h10
`define TCF_A_IRQ_EN_EXT 8'h14
`define TCF_A_FLAGS 8'h18
`define TCF_A_FLAGS_EXT 8'h1c
`define TCF_A_CTRL 8'h20
`define TCF_A_STATUS 8'h24
`define TCF_A_MASK 8'h28

// ************************************************************
// bit positions, timer 1 in the base registers
// ************************************************************
`define TCF_T1_WRAP 7
`define TCF_T1_MA 6
`define TCF_T1_MB 5
`define TCF_T1_CAP 3

// ************************************************************
// bit positions, timer 3 in the extended registers
// ************************************************************
`define TCF_T3_CAP 5
`define TCF_T3_MA 4
`define TCF_T3_MB 3
`define TCF_T3_WRAP 2

// ************************************************************
// control register fields and status bits
// ************************************************************
`define TCF_C_SRC_CMP 0
`define TCF_C_EDGE_T1 1
`define TCF_C_EDGE_T3 2
`define TCF_S_CAP_T1 0
`define TCF_S_CAP_T3 1

// ************************************************************
// reset values and constants
// ************************************************************
`define TCF_RST8 8'h00
`define TCF_RST16 16'h0000
`define TCF_RST32 32'h0000_0000
`define TCF_RST2 2'h0
`define TCF_RST3 3'h0
`define TCF_RST4 4'h0
`define TCF_SYNC_FILL 3'h4
`define TCF_MAX 16'hffff
`define TCF_HTRANS_NSEQ 2'b10

// ************************************************************
// waveform mode codes
// ************************************************************
`define TCF_M_NORMAL 4'h0
`define TCF_M_CTC_CMP 4'h4
`define TCF_M_PFC_CAP 4'h8
`define TCF_M_PC_CAP 4'ha
`define TCF_M_CTC_CAP 4'hc
`define TCF_M_FAST_CAP 4'he

`endif

// ---- rtl/tcf_top.v ----
// capture registers, event flags and interrupt requests for 16-bit timers 1 and 3
// assumes the counter sequencer, compare registers and prescaler sit outside and
// run on hclk; capture pins and comparator output are asynchronous
`include "tcf_regs.vh"

module tcf_top (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [15:0] count_value_t1,
	input wire [15:0] count_value_t3,
	input wire [15:0] compare_a_t1,
	input wire [15:0] compare_b_t1,
	input wire [15:0] compare_a_t3,
	input wire [15:0] compare_b_t3,
	input wire [3:0] waveform_mode_sel_t1,
	input wire [3:0] waveform_mode_sel_t3,
	input wire timer_tick_t1,
	input wire timer_tick_t3,
	input wire top_hit_t1,
	input wire top_hit_t3,
	input wire capture_pin_t1,
	input wire capture_pin_t3,
	input wire comparator_out,
	input wire global_irq_en,
	input wire [3:0] vector_ack_t1,
	input wire [3:0] vector_ack_t3,
	output reg [3:0] irq_req_t1,
	output reg [3:0] irq_req_t3,
	output reg [15:0] ceiling_value_t1,
	output reg [15:0] ceiling_value_t3,
	output reg irq
);

	// ************************************************************
	// internal flag order per timer: 0 wrap, 1 match b, 2 match a, 3 capture
	// ************************************************************
	wire [31:0] cnt_all;
	wire [31:0] cmpa_all;
	wire [31:0] cmpb_all;
	wire [7:0] mode_all;
	wire [1:0] tick_all;
	wire [1:0] top_all;
	wire [7:0] ack_all;
	wire [7:0] set_ev;
	wire [1:0] cap_evt;
	wire [1:0] cap_wr;
	wire [2:0] pin_edge;
	wire [2:0] pin_raw;
	wire [2:0] pin_rise_sel;
	wire [15:0] cap_q [0:1];
	reg [2:0] fill_q;
	wire sync_primed;
	reg [7:0] flag_q;
	reg [7:0] flag_d;
	reg [7:0] en_q;
	reg [7:0] temp_q;
	reg [7:0] ctrl_q;
	reg [1:0] stat_q;
	reg [1:0] stat_d;
	reg [1:0] mask_q;
	reg pend_q;
	reg pend_wr_q;
	reg [7:0] pend_addr_q;
	reg [7:0] w1c;
	reg [1:0] stat_rd_clr;
	reg [31:0] rd_d;

	assign cnt_all = {count_value_t3, count_value_t1};
	assign cmpa_all = {compare_a_t3, compare_a_t1};
	assign cmpb_all = {compare_b_t3, compare_b_t1};
	assign mode_all = {waveform_mode_sel_t3, waveform_mode_sel_t1};
	assign tick_all = {timer_tick_t3, timer_tick_t1};
	assign top_all = {top_hit_t3, top_hit_t1};
	assign ack_all = {vector_ack_t3, vector_ack_t1};
	assign pin_raw = {comparator_out, capture_pin_t3, capture_pin_t1};
	assign pin_rise_sel = {ctrl_q[`TCF_C_EDGE_T1], ctrl_q[`TCF_C_EDGE_T3],
		ctrl_q[`TCF_C_EDGE_T1]};

	// ************************************************************
	// pin synchronisers and edge detection
	// ************************************************************
	// a change counts only once stages two and three agree; the first stage
	// feeds nothing but the second, so metastability stays contained
	// the stages hold reset zeros for a few cycles; until they carry the pin,
	// level just follows stage three, so an idle-high pin gives no false edge
	assign sync_primed = (fill_q == `TCF_SYNC_FILL);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fill_q <= `TCF_RST3;
		else if (!sync_primed)
			fill_q <= fill_q + 3'h1;
	end

	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg level_q;
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					level_q <= 1'b0;
				end else begin
					s1_q <= pin_raw[p];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (!sync_primed || (s2_q == s3_q))
						level_q <= s3_q;
				end
			end
			// edge select 1 means rising, 0 falling
			assign pin_edge[p] = sync_primed && (s2_q == s3_q) && (s3_q != level_q) &&
				(s3_q == pin_rise_sel[p]);
		end
	endgenerate

	// comparator source option, timer 1 only
	assign cap_evt[0] = ctrl_q[`TCF_C_SRC_CMP] ? pin_edge[2] : pin_edge[0];
	assign cap_evt[1] = pin_edge[1];

	// ************************************************************
	// per-timer capture register and flag events
	// ************************************************************
	genvar t;
	generate
		for (t = 0; t < 2; t = t + 1) begin : g_tmr
			wire [15:0] cnt;
			wire [3:0] mode;
			wire tick;
			wire cap_top;
			wire plain_mode;
			reg ma_q;
			reg mb_q;
			assign cnt = cnt_all[16*t +: 16];
			assign mode = mode_all[4*t +: 4];
			assign tick = tick_all[t];
			assign cap_top = (mode == `TCF_M_PFC_CAP) || (mode == `TCF_M_PC_CAP) ||
				(mode == `TCF_M_CTC_CAP) || (mode == `TCF_M_FAST_CAP);
			assign plain_mode = (mode == `TCF_M_NORMAL) || (mode == `TCF_M_CTC_CMP) ||
				(mode == `TCF_M_CTC_CAP);

			// compare result held until the next timer cycle
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ma_q <= 1'b0;
					mb_q <= 1'b0;
				end else if (tick) begin
					ma_q <= (cnt == cmpa_all[16*t +: 16]);
					mb_q <= (cnt == cmpb_all[16*t +: 16]);
				end
			end
			// only the held compare result sets a match flag
			assign set_ev[4*t+2] = tick && ma_q;
			assign set_ev[4*t+1] = tick && mb_q;

			// overflow in normal and clear modes, sequencer top otherwise
			assign set_ev[4*t] = tick && (plain_mode ? (cnt == `TCF_MAX) : top_all[t]);

			// pin event, ceiling reached when used as top
			assign set_ev[4*t+3] = cap_top ? (tick && (cnt == cap_q[t])) : cap_evt[t];

			reg [15:0] val_q;
			// copy count on pin event unless used as top, cpu write has priority
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					val_q <= `TCF_RST16;
				else if (cap_wr[t])
					val_q <= {temp_q, hwdata[7:0]};
				else if (!cap_top && cap_evt[t])
					val_q <= cnt;
			end
			assign cap_q[t] = val_q;
		end
	endgenerate

	// ************************************************************
	// bus slave: one wait state, data phase action
	// ************************************************************
	// every access takes one extra cycle so read data and side effects come
	// from flops; this costs bandwidth but keeps hrdata glitch free
	wire take = hsel && (htrans == `TCF_HTRANS_NSEQ) && hready;
	wire do_wr = pend_q && pend_wr_q;
	wire do_rd = pend_q && !pend_wr_q;

	// low byte write pairs with the held high byte
	assign cap_wr[0] = do_wr && (pend_addr_q == `TCF_A_CAP1_LO);
	assign cap_wr[1] = do_wr && (pend_addr_q == `TCF_A_CAP3_LO);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 1'b0;
			pend_wr_q <= 1'b0;
			pend_addr_q <= `TCF_RST8;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= `TCF_RST32;
		end else begin
			hresp <= 1'b0;
			if (pend_q) begin
				pend_q <= 1'b0;
				hreadyout <= 1'b1;
				if (!pend_wr_q)
					hrdata <= rd_d;
			end else if (take) begin
				pend_q <= 1'b1;
				pend_wr_q <= hwrite;
				pend_addr_q <= haddr[7:0];
				hreadyout <= 1'b0;
			end
		end
	end

	// ************************************************************
	// read mux and read side effects
	// ************************************************************
	always @* begin
		rd_d = `TCF_RST32;
		case (pend_addr_q)
			`TCF_A_CAP1_LO: begin
				rd_d[7:0] = cap_q[0][7:0];
			end
			`TCF_A_CAP3_LO: begin
				rd_d[7:0] = cap_q[1][7:0];
			end
			`TCF_A_CAP1_HI, `TCF_A_CAP3_HI: begin
				rd_d[7:0] = temp_q;
			end
			`TCF_A_IRQ_EN: begin
				rd_d[`TCF_T1_WRAP] = en_q[0];
				rd_d[`TCF_T1_MA] = en_q[2];
				rd_d[`TCF_T1_MB] = en_q[1];
				rd_d[`TCF_T1_CAP] = en_q[3];
			end
			`TCF_A_IRQ_EN_EXT: begin
				rd_d[`TCF_T3_WRAP] = en_q[4];
				rd_d[`TCF_T3_MA] = en_q[6];
				rd_d[`TCF_T3_MB] = en_q[5];
				rd_d[`TCF_T3_CAP] = en_q[7];
			end
			`TCF_A_FLAGS: begin
				rd_d[`TCF_T1_WRAP] = flag_q[0];
				rd_d[`TCF_T1_MA] = flag_q[2];
				rd_d[`TCF_T1_MB] = flag_q[1];
				rd_d[`TCF_T1_CAP] = flag_q[3];
			end
			// timer 3 flags, unused bits stay zero
			`TCF_A_FLAGS_EXT: begin
				rd_d[`TCF_T3_WRAP] = flag_q[4];
				rd_d[`TCF_T3_MA] = flag_q[6];
				rd_d[`TCF_T3_MB] = flag_q[5];
				rd_d[`TCF_T3_CAP] = flag_q[7];
			end
			`TCF_A_CTRL: begin
				rd_d[7:0] = ctrl_q;
			end
			`TCF_A_STATUS: begin
				rd_d[1:0] = stat_q;
			end
			`TCF_A_MASK: begin
				rd_d[1:0] = mask_q;
			end
			default: begin
				rd_d = `TCF_RST32;
			end
		endcase
	end

	// ************************************************************
	// control registers and holding byte
	// ************************************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= `TCF_RST8;
			ctrl_q <= `TCF_RST8;
			mask_q <= `TCF_RST2;
			temp_q <= `TCF_RST8;
		end else begin
			// one shared holding byte: low read latches high, high write parks it
			if (do_rd && (pend_addr_q == `TCF_A_CAP1_LO))
				temp_q <= cap_q[0][15:8];
			else if (do_rd && (pend_addr_q == `TCF_A_CAP3_LO))
				temp_q <= cap_q[1][15:8];
			else if (do_wr && ((pend_addr_q == `TCF_A_CAP1_HI) ||
				(pend_addr_q == `TCF_A_CAP3_HI)))
				temp_q <= hwdata[7:0];
			if (do_wr && (pend_addr_q == `TCF_A_IRQ_EN)) begin
				en_q[0] <= hwdata[`TCF_T1_WRAP];
				en_q[1] <= hwdata[`TCF_T1_MB];
				en_q[2] <= hwdata[`TCF_T1_MA];
				en_q[3] <= hwdata[`TCF_T1_CAP];
			end
			if (do_wr && (pend_addr_q == `TCF_A_IRQ_EN_EXT)) begin
				en_q[4] <= hwdata[`TCF_T3_WRAP];
				en_q[5] <= hwdata[`TCF_T3_MB];
				en_q[6] <= hwdata[`TCF_T3_MA];
				en_q[7] <= hwdata[`TCF_T3_CAP];
			end
			if (do_wr && (pend_addr_q == `TCF_A_CTRL))
				ctrl_q <= hwdata[7:0];
			if (do_wr && (pend_addr_q == `TCF_A_MASK))
				mask_q <= hwdata[1:0];
		end
	end

	// ************************************************************
	// event flags and interrupt requests
	// ************************************************************
	always @* begin
		w1c = `TCF_RST8;
		// written one clears, written zero leaves the flag
		if (do_wr && (pend_addr_q == `TCF_A_FLAGS)) begin
			w1c[0] = hwdata[`TCF_T1_WRAP];
			w1c[1] = hwdata[`TCF_T1_MB];
			w1c[2] = hwdata[`TCF_T1_MA];
			w1c[3] = hwdata[`TCF_T1_CAP];
		end
		if (do_wr && (pend_addr_q == `TCF_A_FLAGS_EXT)) begin
			w1c[4] = hwdata[`TCF_T3_WRAP];
			w1c[5] = hwdata[`TCF_T3_MB];
			w1c[6] = hwdata[`TCF_T3_MA];
			w1c[7] = hwdata[`TCF_T3_CAP];
		end
		// set term applied last so it wins
		flag_d = (flag_q & ~(w1c | ack_all)) | set_ev;
		stat_rd_clr = (do_rd && (pend_addr_q == `TCF_A_STATUS)) ? 2'b11 : 2'b00;
		stat_d = (stat_q & ~stat_rd_clr) | {set_ev[7], set_ev[3]};
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= `TCF_RST8;
			stat_q <= `TCF_RST2;
			irq <= 1'b0;
			irq_req_t1 <= `TCF_RST4;
			irq_req_t3 <= `TCF_RST4;
			ceiling_value_t1 <= `TCF_RST16;
			ceiling_value_t3 <= `TCF_RST16;
		end else begin
			flag_q <= flag_d;
			stat_q <= stat_d;
			irq <= |(stat_d & mask_q);
			// enable, global flag and event flag together
			irq_req_t1 <= global_irq_en ? (flag_d[3:0] & en_q[3:0]) : 4'h0;
			irq_req_t3 <= global_irq_en ? (flag_d[7:4] & en_q[7:4]) : 4'h0;
			// capture register offered as ceiling to the sequencer
			ceiling_value_t1 <= cap_q[0];
			ceiling_value_t3 <= cap_q[1];
		end
	end

endmodule // tcf_top

// ---- tb/tcf_chk.sv ----
// concurrent checks on the ports of the timer capture and flag block
// assumes it is bound to tcf_top; watches design outputs against their causes
module tcf_chk (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire global_irq_en,
	input wire timer_tick_t1,
	input wire timer_tick_t3,
	input wire [3:0] vector_ack_t1,
	input wire [3:0] vector_ack_t3,
	input wire [3:0] irq_req_t1,
	input wire [3:0] irq_req_t3
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ************************************************************
	// bus and request properties
	// ************************************************************
	okay_resp_a: // bus response
		assert property (hresp == 1'b0) else $error("slave response not okay");
	take_wait_a: // bus handshake
		assert property (hsel && htrans == 2'b10 && hready |=> !hreadyout ##1 hreadyout)
		else $error("wait state not exactly one cycle");
	gate_t1_a:
		assert property (|irq_req_t1 |-> $past(global_irq_en))
		else $error("timer 1 request without global enable");
	gate_t3_a:
		assert property (|irq_req_t3 |-> $past(global_irq_en))
		else $error("timer 3 request without global enable");
	ack_clr_t1_a:
		assert property (vector_ack_t1[0] && !timer_tick_t1 |=> !irq_req_t1[0])
		else $error("timer 1 wrap request survives its vector");
	ack_clr_t3_a:
		assert property (vector_ack_t3[0] && !timer_tick_t3 |=> !irq_req_t3[0])
		else $error("timer 3 wrap request survives its vector");
	// a bus write or a global enable change may raise a request without a tick
	match_tick_a:
		assert property ($rose(irq_req_t1[2]) && $past(hreadyout) && $past(global_irq_en, 2)
			|-> $past(timer_tick_t1)) else $error("match request rose without a tick");
	wrap_tick_a:
		assert property ($rose(irq_req_t3[0]) && $past(hreadyout) && $past(global_irq_en, 2)
			|-> $past(timer_tick_t3)) else $error("wrap request rose without a tick");
endmodule // tcf_chk

// ---- tb/tcf_cpu.sv ----
// cpu side bus master issuing single word transfers
// assumes one slave whose hreadyout comes back as hready
module tcf_cpu (
	input wire hclk,
	input wire hready,
	input wire [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
	end
	// ************************************************************
	// transfer, entered just after a rising edge
	// ************************************************************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		rd = hrdata;
		// released data lines show the inverse so a stale value cannot pass
		hwdata <= ~wd;
	endtask
endmodule // tcf_cpu

// ---- tb/timer16_capture_irq_flags_tb.sv ----
// self-checking bench for the timer capture and flag block
// assumes tcf_regs.vh on the include path; timers are driven by hand
`include "tcf_regs.vh"
module timer16_capture_irq_flags_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [15:0] count_value_t1 = 16'h0000, count_value_t3 = 16'h0000;
	logic [15:0] compare_a_t1 = 16'h0001, compare_b_t1 = 16'h0001;
	logic [15:0] compare_a_t3 = 16'h0001, compare_b_t3 = 16'h0001;
	logic [3:0] waveform_mode_sel_t1 = 4'h0, vector_ack_t1 = 4'h0, vector_ack_t3 = 4'h0;
	logic timer_tick_t1 = 1'b0, timer_tick_t3 = 1'b0, global_irq_en = 1'b1;
	logic [3:0] waveform_mode_sel_t3 = 4'h0;
	logic top_hit_t3 = 1'b0, comparator_out = 1'b0;
	logic capture_pin_t1 = 1'b1, capture_pin_t3 = 1'b1;
	wire hsel, hwrite, hreadyout, hresp, irq;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0] htrans;
	wire [2:0] hsize;
	wire [3:0] irq_req_t1, irq_req_t3;
	wire [15:0] ceiling_value_t1, ceiling_value_t3;
	integer miscompares = 0;
	integer samples_checked = 0;
	always #50 hclk = ~hclk;
	tcf_cpu u_cpu (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	tcf_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.count_value_t1(count_value_t1), .count_value_t3(count_value_t3),
		.compare_a_t1(compare_a_t1), .compare_b_t1(compare_b_t1),
		.compare_a_t3(compare_a_t3), .compare_b_t3(compare_b_t3),
		.waveform_mode_sel_t1(waveform_mode_sel_t1),
		.waveform_mode_sel_t3(waveform_mode_sel_t3),
		.timer_tick_t1(timer_tick_t1), .timer_tick_t3(timer_tick_t3), .top_hit_t1(1'b0),
		.top_hit_t3(top_hit_t3), .capture_pin_t1(capture_pin_t1),
		.capture_pin_t3(capture_pin_t3), .comparator_out(comparator_out),
		.global_irq_en(global_irq_en), .vector_ack_t1(vector_ack_t1),
		.vector_ack_t3(vector_ack_t3), .irq_req_t1(irq_req_t1), .irq_req_t3(irq_req_t3),
		.ceiling_value_t1(ceiling_value_t1), .ceiling_value_t3(ceiling_value_t3), .irq(irq));
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		u_cpu.xfer(1'b1, a, d, v);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] v;
		u_cpu.xfer(1'b0, a, 32'h0000_0000, v);
		check(what, v, exp);
	endtask
	task automatic tick(input logic t3);
		if (t3)
			timer_tick_t3 <= 1'b1;
		else
			timer_tick_t1 <= 1'b1;
		@(posedge hclk);
		timer_tick_t1 <= 1'b0;
		timer_tick_t3 <= 1'b0;
		@(posedge hclk);
	endtask
	task automatic ack(input logic [3:0] a1, input logic [3:0] a3);
		vector_ack_t1 <= a1;
		vector_ack_t3 <= a3;
		@(posedge hclk);
		vector_ack_t1 <= 4'h0;
		vector_ack_t3 <= 4'h0;
		@(posedge hclk);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic s_reset();
		rd(`TCF_A_FLAGS, 32'h0, "flags");
		rd(`TCF_A_FLAGS_EXT, 32'h0, "flags_ext");
		rd(8'h40, 32'h0, "unmapped");
		wr(`TCF_A_IRQ_EN, 32'h0000_00e8);
		rd(`TCF_A_IRQ_EN, 32'h0000_00e8, "irq_en");
		wr(`TCF_A_IRQ_EN_EXT, 32'h0000_003c);
		rd(`TCF_A_IRQ_EN_EXT, 32'h0000_003c, "irq_en_ext");
		wr(`TCF_A_MASK, 32'h0000_0001);
	endtask
	task automatic s_wrap();
		global_irq_en <= 1'b0;
		count_value_t1 <= 16'hffff;
		tick(1'b0);
		rd(`TCF_A_FLAGS, 32'h80, "wrap flag");
		check("req gated", {28'h0, irq_req_t1}, 32'h0);
		global_irq_en <= 1'b1;
		repeat (2) @(posedge hclk);
		check("req wrap", {28'h0, irq_req_t1}, 32'h1);
		wr(`TCF_A_FLAGS, 32'h0);
		rd(`TCF_A_FLAGS, 32'h80, "zero kept");
		ack(4'h1, 4'h0);
		rd(`TCF_A_FLAGS, 32'h0, "vector clear");
	endtask
	task automatic s_match();
		compare_a_t1 <= 16'h1234;
		compare_b_t1 <= 16'h1234;
		count_value_t1 <= 16'h1234;
		tick(1'b0);
		rd(`TCF_A_FLAGS, 32'h0, "match early");
		count_value_t1 <= 16'h1235;
		tick(1'b0);
		rd(`TCF_A_FLAGS, 32'h60, "match flags");
		check("req match", {28'h0, irq_req_t1}, 32'h6);
		ack(4'h6, 4'h0);
		rd(`TCF_A_FLAGS, 32'h0, "match clear");
		compare_a_t1 <= 16'h0001;
		compare_b_t1 <= 16'h0001;
	endtask
	task automatic s_t3();
		count_value_t3 <= 16'hffff;
		compare_a_t3 <= 16'hffff;
		compare_b_t3 <= 16'hffff;
		tick(1'b1);
		tick(1'b1);
		rd(`TCF_A_FLAGS_EXT, 32'h1c, "t3 flags");
		check("req t3", {28'h0, irq_req_t3}, 32'h7);
		ack(4'h0, 4'h1);
		rd(`TCF_A_FLAGS_EXT, 32'h18, "t3 vector");
		wr(`TCF_A_FLAGS_EXT, 32'h0000_00ff);
		rd(`TCF_A_FLAGS_EXT, 32'h0, "t3 w1c");
		count_value_t3 <= 16'h5aa5;
	endtask
	task automatic s_capture();
		count_value_t1 <= 16'habcd;
		capture_pin_t1 <= 1'b0;
		repeat (8) @(posedge hclk);
		check("irq up", {31'h0, irq}, 32'h1);
		rd(`TCF_A_FLAGS, 32'h08, "cap flag");
		rd(`TCF_A_CAP1_LO, 32'hcd, "cap1 lo");
		rd(`TCF_A_CAP1_HI, 32'hab, "cap1 hi");
		check("ceiling1", {16'h0, ceiling_value_t1}, 32'habcd);
		rd(`TCF_A_STATUS, 32'h1, "status1");
		repeat (2) @(posedge hclk);
		check("irq down", {31'h0, irq}, 32'h0);
		wr(`TCF_A_FLAGS, 32'h08);
		rd(`TCF_A_FLAGS, 32'h0, "cap clear");
		capture_pin_t3 <= 1'b0;
		repeat (8) @(posedge hclk);
		rd(`TCF_A_FLAGS_EXT, 32'h20, "cap3 flag");
		rd(`TCF_A_CAP3_LO, 32'ha5, "cap3 lo");
		rd(`TCF_A_CAP3_HI, 32'h5a, "cap3 hi");
		check("ceiling3", {16'h0, ceiling_value_t3}, 32'h5aa5);
		check("irq masked", {31'h0, irq}, 32'h0);
		rd(`TCF_A_STATUS, 32'h2, "status3");
	endtask
	task automatic s_ceiling();
		wr(`TCF_A_CAP1_HI, 32'h12);
		wr(`TCF_A_CAP1_LO, 32'h34);
		rd(`TCF_A_CAP1_LO, 32'h34, "wr lo");
		rd(`TCF_A_CAP1_HI, 32'h12, "wr hi");
		waveform_mode_sel_t1 <= 4'hc;
		count_value_t1 <= 16'h1234;
		tick(1'b0);
		rd(`TCF_A_FLAGS, 32'h08, "top flag");
		check("ceiling top", {16'h0, ceiling_value_t1}, 32'h1234);
	endtask
	// comparator as timer 1 source on rising edges, then a clear that meets a set
	task automatic s_source();
		waveform_mode_sel_t1 <= 4'h4;
		count_value_t1 <= 16'h4321;
		wr(`TCF_A_FLAGS, 32'h08);
		wr(`TCF_A_CTRL, 32'h03);
		rd(`TCF_A_CTRL, 32'h03, "ctrl");
		comparator_out <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(`TCF_A_FLAGS, 32'h08, "cmp flag");
		rd(`TCF_A_CAP1_LO, 32'h21, "cmp lo");
		rd(`TCF_A_CAP1_HI, 32'h43, "cmp hi");
		count_value_t1 <= 16'hffff;
		// the tick lands on the edge at which the write is performed
		fork
			wr(`TCF_A_FLAGS, 32'h88);
			begin
				@(posedge hclk);
				timer_tick_t1 <= 1'b1;
				@(posedge hclk);
				timer_tick_t1 <= 1'b0;
			end
		join
		rd(`TCF_A_FLAGS, 32'h80, "set wins");
	endtask
	// timer 3 with the capture register as ceiling: wrap follows the top strobe
	task automatic s_top3();
		waveform_mode_sel_t3 <= 4'h8;
		compare_a_t3 <= 16'h0001;
		compare_b_t3 <= 16'h0001;
		count_value_t3 <= 16'hffff;
		tick(1'b1);
		// capture flag still up, matches latched in the last timer cycle
		rd(`TCF_A_FLAGS_EXT, 32'h38, "no top");
		wr(`TCF_A_FLAGS_EXT, 32'h0000_00ff);
		top_hit_t3 <= 1'b1;
		tick(1'b1);
		top_hit_t3 <= 1'b0;
		rd(`TCF_A_FLAGS_EXT, 32'h04, "top wrap");
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset();
		s_wrap();
		s_match();
		s_t3();
		s_capture();
		s_ceiling();
		s_source();
		s_top3();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge hclk);
		miscompares++;
		conclude();
	end
endmodule // timer16_capture_irq_flags_tb
bind tcf_top tcf_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .global_irq_en(global_irq_en),
	.timer_tick_t1(timer_tick_t1), .timer_tick_t3(timer_tick_t3),
	.vector_ack_t1(vector_ack_t1), .vector_ack_t3(vector_ack_t3),
	.irq_req_t1(irq_req_t1), .irq_req_t3(irq_req_t3));
